// ===== design/sif_map.svh
// Offsets, field positions, widths and reset values for the store issue control block
`ifndef SIF_MAP_SVH
`define SIF_MAP_SVH

`define SIF_ADDR_W 24
`define SIF_OCT_W 21
`define SIF_OCT_LSB 3
`define SIF_REGA_W 7
`define SIF_MODE_W 2
`define SIF_GATE_W 4
`define SIF_CNT_W 16

`define SIF_AV_ADDR_W 4
`define SIF_OFF_CTRL 4'h0
`define SIF_OFF_STATUS 4'h4
`define SIF_OFF_PEND 4'h8
`define SIF_OFF_FWCNT 4'hC

`define SIF_CTRL_SEQ_EN 0
`define SIF_CTRL_FW_EN 1
`define SIF_CTRL_W 2
`define SIF_CTRL_RST 2'h3

`define SIF_MODE_ZERO 2'h0

`endif

// ===== design/sif_pkg.sv
// Types shared by the store issue and stage 4 control block
package sif_pkg;
`include "sif_map.svh"

  typedef enum logic [1:0] {
    SIF_SEQ_NONE = 2'b00,
    SIF_SEQ_MEMSTORE = 2'b01,
    SIF_SEQ_IDLE = 2'b10
  } sif_seq_t;

  typedef enum logic [1:0] {
    SIF_FW_IDLE = 2'b00,
    SIF_FW_DRAIN = 2'b01,
    SIF_FW_HOLD = 2'b10
  } sif_fw_st_t;

  typedef enum logic [1:0] {
    SIF_L4_START = 2'b00,
    SIF_L4_SWAIT = 2'b01
  } sif_l4_st_t;

  typedef struct packed {
    sif_seq_t seq;
    logic store_modifies;
    logic [`SIF_REGA_W-1:0] level3_regaddr;
    logic [`SIF_ADDR_W-1:0] adder_result_reg;
    logic [`SIF_MODE_W-1:0] stage4_mode_code;
    logic alpha_from_reg;
    logic fw_cmd;
    logic x_valid_clr;
    logic y_valid_clr;
  } sif_l3_t;

  typedef struct packed {
    logic memory_out_octet_full;
    logic sent_octet_full;
    logic data_to_mem;
    logic buffer_input_accept;
    logic stored_to_z;
    logic x_fill_next;
    logic y_fill_next;
    logic x_active;
    logic y_active;
    logic [`SIF_OCT_W-1:0] x_octet_addr;
    logic [`SIF_OCT_W-1:0] y_octet_addr;
    logic [`SIF_OCT_W-1:0] z_octet_addr;
    logic z_octet_valid;
  } sif_mbu_t;

  typedef struct packed {
    logic regfile_target_flag;
    logic last_target_active;
    logic [`SIF_REGA_W-1:0] last_target_reg;
    logic [`SIF_ADDR_W-1:0] stack_entry_addr;
    logic first_word_flag;
    logic [`SIF_ADDR_W-1:0] pending_store_addr;
    logic pending_store_valid;
    logic memory_store_tag;
    logic reg_operand_present;
    logic direct_operand_flag;
    logic level4_active;
    logic x_octet_valid;
    logic y_octet_valid;
    logic [`SIF_GATE_W-1:0] load_gates;
    logic z_matches_x;
    logic z_matches_y;
    logic z_to_x_update;
    logic z_to_y_update;
    logic forced_write_wait;
    logic fw_to_mbu;
    logic level4_accept;
    logic l4_to_l5;
  } sif_out_t;
endpackage

// ===== design/sif_ctrl.sv
// Store issue sequences, forced write controller and stage 4 mode zero control
//
// Notes on behaviour
// - Memory store clears regfile target flag
// - Plain store loads last target from level3
// - Modifying store: no short circuit, clear active
// - Store copies adder result into stack entry
// - New octet store sets first word flag
// - Store loads pending address, valid and tag
// - Store sets operand flags and level4 activity
// - Idle sequence: gates zero, store flags held
// - Concluding sequence clears load gates and updates octet valid flags
// - Fill next sets matching octet valid
// - Forced write idles until level3 command
// - Hold wait until empty and data sent
// - Level4 owns interface while active, unaccepted
// - Level4 actions follow stage4 mode code
// - Match indicators from valid Z octet
// - Set match enables update on forced write
// - Mode zero, idle level4: issue accept
// - Mode zero, active: hold until input accept
// - Alpha from regfile: accept and pass on
// - Alpha from memory: store seen via pending
// - Differing pending store withholds accept
// - Stage4 mode code is two bits
// - Each nonzero mode ends by resetting to mode zero
`timescale 1ns/1ps
`include "sif_map.svh"

module sif_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sif_pkg::sif_l3_t i_l3,
  input wire sif_pkg::sif_mbu_t i_mbu,
  input wire logic [`SIF_AV_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output sif_pkg::sif_out_t o_ctl
);
  import sif_pkg::*;

  typedef struct packed {
    sif_fw_st_t fw_st;
    sif_l4_st_t l4_st;
    logic [`SIF_MODE_W-1:0] mode;
    logic [`SIF_CTRL_W-1:0] ctrl;
    logic [`SIF_CNT_W-1:0] fw_count;
    logic av_wait;
    logic [31:0] av_rdata;
    sif_out_t o;
  } sif_state_t;

  sif_state_t st_q;
  sif_state_t st_d;
  logic go_store;
  logic go_idle;
  logic l4_own;
  logic new_octet;
  logic fw_drained;
  logic [31:0] status_word;
  logic [`SIF_OCT_W-1:0] ar_oct;

  assign go_store = (i_l3.seq == SIF_SEQ_MEMSTORE) && st_q.ctrl[`SIF_CTRL_SEQ_EN];
  assign go_idle = (i_l3.seq == SIF_SEQ_IDLE) && st_q.ctrl[`SIF_CTRL_SEQ_EN];
  // Level 4 drives the interface only with work in hand that level 3 waits on
  assign l4_own = st_q.o.level4_active && !st_q.o.level4_accept;
  assign ar_oct = i_l3.adder_result_reg[`SIF_ADDR_W-1:`SIF_OCT_LSB];
  // Already present means resident in Z or awaited by an earlier pending store
  assign new_octet = !((i_mbu.z_octet_valid && (ar_oct == i_mbu.z_octet_addr)) ||
    (st_q.o.pending_store_valid &&
    (ar_oct == st_q.o.pending_store_addr[`SIF_ADDR_W-1:`SIF_OCT_LSB])));
  assign fw_drained = !i_mbu.memory_out_octet_full && !i_mbu.sent_octet_full;
  assign status_word = {16'h0000, st_q.o.last_target_active, st_q.o.regfile_target_flag,
    st_q.o.first_word_flag, st_q.o.z_matches_y, st_q.o.z_matches_x,
    st_q.o.y_octet_valid, st_q.o.x_octet_valid, st_q.o.forced_write_wait,
    st_q.o.level4_active, st_q.o.pending_store_valid, st_q.mode, st_q.l4_st, st_q.fw_st};

  always_comb begin
    st_d = st_q;
    // One-cycle strobes fall back unless raised below
    st_d.o.fw_to_mbu = 1'b0;
    st_d.o.level4_accept = 1'b0;
    st_d.o.l4_to_l5 = 1'b0;
    st_d.o.z_to_x_update = 1'b0;
    st_d.o.z_to_y_update = 1'b0;

    // Level 3 sequences; both end in the shared concluding part
    if (go_store) begin
      st_d.o.regfile_target_flag = 1'b0;
      if (!i_l3.store_modifies) begin
        st_d.o.last_target_active = 1'b1;
        st_d.o.last_target_reg = i_l3.level3_regaddr;
      end else begin
        // A memory address does not fit the 7 bit target, so short circuit is off
        st_d.o.last_target_active = 1'b0;
      end
      st_d.o.stack_entry_addr = i_l3.adder_result_reg;
      st_d.o.first_word_flag = new_octet;
      st_d.o.pending_store_addr = i_l3.adder_result_reg;
      st_d.o.memory_store_tag = 1'b1;
      st_d.o.reg_operand_present = 1'b1;
      st_d.o.direct_operand_flag = 1'b1;
      st_d.o.level4_active = 1'b1;
      st_d.mode = i_l3.stage4_mode_code;
    end
    if (go_store || go_idle) begin
      // Idle sequence touches no store flag; gates are forced low and octet valids follow fill next
      st_d.o.load_gates = '0;
      if (i_mbu.x_fill_next) begin
        st_d.o.x_octet_valid = 1'b1;
      end else if (i_l3.x_valid_clr) begin
        st_d.o.x_octet_valid = 1'b0;
      end
      if (i_mbu.y_fill_next) begin
        st_d.o.y_octet_valid = 1'b1;
      end else if (i_l3.y_valid_clr) begin
        st_d.o.y_octet_valid = 1'b0;
      end
    end else begin
      if (i_l3.x_valid_clr) begin
        st_d.o.x_octet_valid = 1'b0;
      end
      if (i_l3.y_valid_clr) begin
        st_d.o.y_octet_valid = 1'b0;
      end
    end

    // A new store setting pending-valid wins over the drain into Z
    if (go_store) begin
      st_d.o.pending_store_valid = 1'b1;
    end else if (i_mbu.stored_to_z) begin
      st_d.o.pending_store_valid = 1'b0;
    end

    // Match indicators are refreshed every cycle
    st_d.o.z_matches_x = i_mbu.z_octet_valid && i_mbu.x_active && st_q.o.x_octet_valid &&
      (i_mbu.x_octet_addr == i_mbu.z_octet_addr);
    st_d.o.z_matches_y = i_mbu.z_octet_valid && i_mbu.y_active && st_q.o.y_octet_valid &&
      (i_mbu.y_octet_addr == i_mbu.z_octet_addr);
    // Update rides on the clock after Z is pushed out
    st_d.o.z_to_x_update = st_q.o.fw_to_mbu && st_q.o.z_matches_x;
    st_d.o.z_to_y_update = st_q.o.fw_to_mbu && st_q.o.z_matches_y;

    // Forced write controller
    case (st_q.fw_st)
      SIF_FW_IDLE: begin
        if (i_l3.fw_cmd && st_q.ctrl[`SIF_CTRL_FW_EN]) begin
          st_d.fw_st = SIF_FW_DRAIN;
        end
      end
      SIF_FW_DRAIN: begin
        if (fw_drained) begin
          st_d.o.forced_write_wait = 1'b1;
          st_d.o.fw_to_mbu = 1'b1;
          st_d.fw_st = SIF_FW_HOLD;
        end
      end
      SIF_FW_HOLD: begin
        if (fw_drained && i_mbu.data_to_mem) begin
          st_d.o.forced_write_wait = 1'b0;
          st_d.fw_st = SIF_FW_IDLE;
          st_d.fw_count = st_q.fw_count + `SIF_CNT_W'(1);
        end
      end
      default: begin
        st_d.fw_st = SIF_FW_IDLE;
      end
    endcase

    // Level 4 controller; only mode zero is carried out here
    case (st_q.l4_st)
      SIF_L4_START: begin
        if (st_q.mode != `SIF_MODE_ZERO) begin
          // Other modes conclude by dropping to mode zero for the next clock
          st_d.mode = `SIF_MODE_ZERO;
        end else if (!st_q.o.level4_active) begin
          st_d.o.level4_accept = 1'b1;
        end else if (l4_own && i_mbu.buffer_input_accept) begin
          st_d.o.l4_to_l5 = 1'b1;
          st_d.o.level4_active = 1'b0;
          if (i_l3.alpha_from_reg) begin
            st_d.o.level4_accept = 1'b1;
          end else if (st_q.o.pending_store_valid &&
            (i_l3.adder_result_reg != st_q.o.pending_store_addr)) begin
            st_d.l4_st = SIF_L4_SWAIT;
          end else begin
            st_d.o.level4_accept = 1'b1;
          end
        end
        // Otherwise loop; level4_active keeps its value, accept and l4_to_l5 fall back to zero
      end
      SIF_L4_SWAIT: begin
        if (!st_q.o.pending_store_valid) begin
          st_d.o.level4_accept = 1'b1;
          st_d.l4_st = SIF_L4_START;
        end
      end
      default: begin
        st_d.l4_st = SIF_L4_START;
      end
    endcase
    if (go_store) begin
      st_d.o.level4_active = 1'b1;
    end

    // Avalon slave: one wait state, then the answer edge
    st_d.av_wait = !((i_avs_read || i_avs_write) && st_q.av_wait);
    if (i_avs_read && st_q.av_wait) begin
      if (i_avs_address == `SIF_OFF_CTRL) begin
        st_d.av_rdata = {30'h00000000, st_q.ctrl};
      end else if (i_avs_address == `SIF_OFF_STATUS) begin
        st_d.av_rdata = status_word;
      end else if (i_avs_address == `SIF_OFF_PEND) begin
        st_d.av_rdata = {8'h00, st_q.o.pending_store_addr};
      end else if (i_avs_address == `SIF_OFF_FWCNT) begin
        st_d.av_rdata = {16'h0000, st_q.fw_count};
      end else begin
        st_d.av_rdata = 32'h00000000;
      end
    end
    if (i_avs_write && !st_q.av_wait && i_avs_byteenable[0]) begin
      if (i_avs_address == `SIF_OFF_CTRL) begin
        st_d.ctrl = i_avs_writedata[`SIF_CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '0;
      st_q.ctrl <= `SIF_CTRL_RST;
      st_q.av_wait <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_ctl = st_q.o;
  assign o_avs_readdata = st_q.av_rdata;
  assign o_avs_waitrequest = st_q.av_wait;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  regfile_target_flag_clear_a: assert property (go_store |=> !o_ctl.regfile_target_flag)
    else $error("store did not clear regfile target flag");
  last_target_a: assert property (go_store && !i_l3.store_modifies |=>
    o_ctl.last_target_active && o_ctl.last_target_reg == $past(i_l3.level3_regaddr))
    else $error("plain store did not load last target");
  no_short_a: assert property (go_store && i_l3.store_modifies |=>
    !o_ctl.last_target_active)
    else $error("modifying store left last target active");
  stack_addr_a: assert property (go_store |=>
    o_ctl.stack_entry_addr == $past(i_l3.adder_result_reg))
    else $error("stack entry address not copied");
  first_word_a: assert property (go_store |=> o_ctl.first_word_flag == $past(new_octet))
    else $error("first word flag wrong");
  pend_store_a: assert property (go_store |=> o_ctl.pending_store_valid &&
    o_ctl.memory_store_tag && o_ctl.pending_store_addr == $past(i_l3.adder_result_reg))
    else $error("pending store not recorded");
  store_flags_a: assert property (go_store |=> o_ctl.reg_operand_present &&
    o_ctl.direct_operand_flag && o_ctl.level4_active)
    else $error("store operand flags not set");
  idle_hold_a: assert property (go_idle |=> o_ctl.load_gates == '0 &&
    $stable(o_ctl.regfile_target_flag) && $stable(o_ctl.last_target_active))
    else $error("idle sequence changed flags");
  xfill_a: assert property ((go_store || go_idle) && i_mbu.x_fill_next |=>
    o_ctl.x_octet_valid)
    else $error("x octet valid not set on fill");
  fw_start_a: assert property (st_q.fw_st == SIF_FW_DRAIN && fw_drained |=>
    o_ctl.forced_write_wait && o_ctl.fw_to_mbu ##1 !o_ctl.fw_to_mbu)
    else $error("forced write start wrong");
  fw_hold_a: assert property (o_ctl.forced_write_wait &&
    !(fw_drained && i_mbu.data_to_mem) |=> o_ctl.forced_write_wait)
    else $error("forced write wait dropped early");
  fw_drop_a: assert property (st_q.fw_st == SIF_FW_HOLD && fw_drained &&
    i_mbu.data_to_mem |=> !o_ctl.forced_write_wait && st_q.fw_st == SIF_FW_IDLE)
    else $error("forced write wait not dropped at idle");
  zmatch_a: assert property (!i_mbu.z_octet_valid |=>
    !o_ctl.z_matches_x && !o_ctl.z_matches_y)
    else $error("match indicator set without valid Z");
  update_a: assert property (o_ctl.fw_to_mbu && o_ctl.z_matches_x |=>
    o_ctl.z_to_x_update)
    else $error("Z to X update missing");
  mode0_acc_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode == 2'h0 &&
    !o_ctl.level4_active |=> o_ctl.level4_accept)
    else $error("idle level 4 gave no accept");
  mode0_loop_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode == 2'h0 &&
    o_ctl.level4_active && !i_mbu.buffer_input_accept |=> !o_ctl.l4_to_l5)
    else $error("level 4 passed on without input accept");
  alpha_reg_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode == 2'h0 &&
    l4_own && i_mbu.buffer_input_accept && i_l3.alpha_from_reg |=>
    o_ctl.level4_accept && o_ctl.l4_to_l5)
    else $error("register alpha not accepted");
  store_wait_a: assert property (st_q.l4_st == SIF_L4_SWAIT &&
    o_ctl.pending_store_valid |=> !o_ctl.level4_accept)
    else $error("accept given while store pending");
  mode_reset_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode != 2'h0 |=>
    st_q.mode == 2'h0)
    else $error("mode not reset to zero");

  // Store, concluding and idle sequences
  yfill_a: assert property ((go_store || go_idle) && i_mbu.y_fill_next |=>
    o_ctl.y_octet_valid)
    else $error("y octet valid not set on fill");
  gates_clear_a: assert property ((go_store || go_idle) |=> o_ctl.load_gates == '0)
    else $error("load gates left open");
  idle_keep_a: assert property (go_idle |=> $stable(o_ctl.stack_entry_addr) &&
    $stable(o_ctl.pending_store_addr) && $stable(o_ctl.first_word_flag))
    else $error("idle sequence moved store state");
  mode_load_a: assert property (go_store && st_q.mode == `SIF_MODE_ZERO |=>
    st_q.mode == $past(i_l3.stage4_mode_code))
    else $error("stage 4 mode code not taken");

  // Forced write controller; the wait must never outlive the hold state
  fw_idle_a: assert property (st_q.fw_st == SIF_FW_IDLE && !i_l3.fw_cmd |=>
    st_q.fw_st == SIF_FW_IDLE)
    else $error("forced write left idle without command");
  fw_quiet_a: assert property (st_q.fw_st == SIF_FW_IDLE |-> !o_ctl.forced_write_wait)
    else $error("forced write wait high in idle");
  fw_drain_a: assert property (st_q.fw_st == SIF_FW_DRAIN && !fw_drained |=>
    !o_ctl.fw_to_mbu && !o_ctl.forced_write_wait)
    else $error("forced write began before drain");
  fw_pulse_a: assert property (o_ctl.fw_to_mbu |=> !o_ctl.fw_to_mbu)
    else $error("forced write command too long");

  // Update enable
  zmatch_x_a: assert property (i_mbu.z_octet_valid && i_mbu.x_active &&
    o_ctl.x_octet_valid && i_mbu.x_octet_addr == i_mbu.z_octet_addr |=> o_ctl.z_matches_x)
    else $error("Z matches X not set");
  zmatch_y_a: assert property (i_mbu.z_octet_valid && i_mbu.y_active &&
    o_ctl.y_octet_valid && i_mbu.y_octet_addr == i_mbu.z_octet_addr |=> o_ctl.z_matches_y)
    else $error("Z matches Y not set");
  update_y_a: assert property (o_ctl.fw_to_mbu && o_ctl.z_matches_y |=>
    o_ctl.z_to_y_update)
    else $error("Z to Y update missing");
  no_update_a: assert property (!o_ctl.fw_to_mbu |=>
    !o_ctl.z_to_x_update && !o_ctl.z_to_y_update)
    else $error("update without forced write");

  // Level 4 mode zero, nonzero modes quiet; a different pending store must reach Z first
  own_pass_a: assert property (o_ctl.l4_to_l5 |->
    $past(o_ctl.level4_active) && !$past(o_ctl.level4_accept))
    else $error("level 4 passed on without owning");
  alpha_mem_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode == 2'h0 &&
    l4_own && i_mbu.buffer_input_accept && !i_l3.alpha_from_reg &&
    !o_ctl.pending_store_valid |=> o_ctl.level4_accept && o_ctl.l4_to_l5)
    else $error("memory alpha not accepted");
  store_diff_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode == 2'h0 &&
    l4_own && i_mbu.buffer_input_accept && !i_l3.alpha_from_reg &&
    o_ctl.pending_store_valid && i_l3.adder_result_reg != o_ctl.pending_store_addr |=>
    !o_ctl.level4_accept && st_q.l4_st == SIF_L4_SWAIT)
    else $error("differing store not withheld");
  swait_end_a: assert property (st_q.l4_st == SIF_L4_SWAIT &&
    !o_ctl.pending_store_valid |=> o_ctl.level4_accept && st_q.l4_st == SIF_L4_START)
    else $error("accept missing after store drained");
  pend_keep_a: assert property (o_ctl.pending_store_valid && !i_mbu.stored_to_z |=>
    o_ctl.pending_store_valid)
    else $error("pending store dropped early");
  mode_quiet_a: assert property (st_q.l4_st == SIF_L4_START && st_q.mode != 2'h0 |=>
    !o_ctl.level4_accept && !o_ctl.l4_to_l5)
    else $error("nonzero mode acted");

  store_seq_c: cover property (go_store ##1 o_ctl.level4_active);
  fw_cycle_c: cover property (o_ctl.fw_to_mbu ##[1:50] !o_ctl.forced_write_wait);
  swait_c: cover property (st_q.l4_st == SIF_L4_SWAIT ##[1:50] o_ctl.level4_accept);
  update_c: cover property (o_ctl.z_to_y_update);
  fw_drain_c: cover property (st_q.fw_st == SIF_FW_DRAIN ##1 st_q.fw_st == SIF_FW_HOLD);
endmodule

// ===== sim/sif_mbu_model.sv
// Memory buffer unit model: drain, input accept and pipe store timing
`timescale 1ns/1ps
module sif_mbu_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sif_pkg::sif_out_t i_ctl,
  input wire sif_pkg::sif_mbu_t i_base,
  input wire logic i_pre_full,
  input wire logic [3:0] i_lat,
  output sif_pkg::sif_mbu_t o_mbu
);
  import sif_pkg::*;
  logic [3:0] fw_q;
  logic [3:0] bia_q;
  logic [5:0] z_q;

  // Input accept and pipe store counters reload only from zero; the forced write counter reloads on every command
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fw_q <= 4'h0;
      bia_q <= 4'h0;
      z_q <= 6'h00;
    end else begin
      if (i_ctl.fw_to_mbu) fw_q <= i_lat;
      else if (fw_q != 4'h0) fw_q <= fw_q - 4'h1;
      if (i_ctl.level4_active && bia_q == 4'h0) bia_q <= i_lat;
      else if (bia_q != 4'h0) bia_q <= bia_q - 4'h1;
      // Pipe store lands in Z well after the input accept
      if (i_ctl.pending_store_valid && z_q == 6'h00) z_q <= {i_lat, 2'b00};
      else if (z_q != 6'h00) z_q <= z_q - 6'h01;
    end
  end

  always_comb begin
    o_mbu = i_base;
    o_mbu.memory_out_octet_full = i_pre_full || fw_q > 4'h1;
    o_mbu.sent_octet_full = i_pre_full || fw_q > 4'h2;
    o_mbu.data_to_mem = fw_q == 4'h1;
    o_mbu.buffer_input_accept = bia_q == 4'h1;
    o_mbu.stored_to_z = z_q == 6'h01;
  end
endmodule

// ===== sim/sif_ctrl_test.sv
// Self-checking bench for the store issue and stage 4 control block
`timescale 1ns/1ps
`include "sif_map.svh"
module sif_ctrl_test;
  import sif_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  sif_l3_t l3 = '0;
  sif_mbu_t base = '0;
  sif_mbu_t mbu;
  sif_out_t ctl;
  logic [3:0] av_a = 4'h0;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [3:0] av_be = 4'hF;
  logic [31:0] av_rd;
  logic av_wait;
  logic pre_full = 1'b0;
  logic [3:0] lat = 4'h2;
  logic [31:0] rng = 32'h60;
  logic [31:0] rdat;
  logic [23:0] ar;
  int num_errors = 0;
  int n_compared = 0;
  int exp_fw = 0;
  logic [23:0] exp_pend[$];

  sif_ctrl i_sif_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_l3(l3), .i_mbu(mbu),
    .i_avs_address(av_a), .i_avs_read(av_r), .i_avs_write(av_w), .i_avs_writedata(av_wd),
    .i_avs_byteenable(av_be), .o_avs_readdata(av_rd), .o_avs_waitrequest(av_wait),
    .o_ctl(ctl));
  sif_mbu_model i_sif_mbu_model (.i_clk(i_clk), .i_rst(i_rst), .i_ctl(ctl), .i_base(base),
    .i_pre_full(pre_full), .i_lat(lat), .o_mbu(mbu));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Request held until the edge that samples waitrequest low; one idle edge after
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_a <= a;
    av_wd <= d;
    av_w <= wr;
    av_r <= !wr;
    @(posedge i_clk);
    while (av_wait !== 1'b0) begin
      if (n++ > 50) begin
        num_errors++;
        report_and_stop();
      end
      @(posedge i_clk);
    end
    rdat = av_rd;
    av_w <= 1'b0;
    av_r <= 1'b0;
    tick(1);
  endtask

  task automatic wait_ctl(input int k);
    logic s;
    for (int n = 0; n < 100; n++) begin
      @(posedge i_clk);
      s = k == 0 ? ctl.fw_to_mbu : k == 1 ? ctl.l4_to_l5 :
          k == 2 ? !ctl.forced_write_wait : ctl.level4_accept;
      if (s === 1'b1) return;
    end
    num_errors++;
    report_and_stop();
  endtask

  task automatic store(input logic md, input logic [1:0] mode, input logic zh);
    logic [6:0] ra;
    ra = ar[6:0] ^ 7'h55;
    exp_pend.push_back(ar);
    base.z_octet_valid <= zh;
    base.z_octet_addr <= zh ? ar[23:3] : ~ar[23:3];
    l3.seq <= SIF_SEQ_MEMSTORE;
    l3.store_modifies <= md;
    l3.stage4_mode_code <= mode;
    l3.adder_result_reg <= ar;
    l3.level3_regaddr <= ra;
    tick(1);
    l3.seq <= SIF_SEQ_NONE;
    tick(1);
    check("regfile_tgt", ctl.regfile_target_flag, 1'b0);
    check("lt_active", ctl.last_target_active, !md);
    if (!md) check("lt_reg", ctl.last_target_reg, ra);
    check("stack_addr", ctl.stack_entry_addr, ar);
    check("first_word", ctl.first_word_flag, !zh);
    check("pend", {ctl.pending_store_valid, ctl.memory_store_tag, ctl.pending_store_addr},
      {2'h3, exp_pend[$]});
    check("flags", {ctl.reg_operand_present, ctl.direct_operand_flag, ctl.level4_active},
      3'h7);
    check("gates", ctl.load_gates, 4'h0);
  endtask

  initial begin
    tick(5);
    check("rst_out", {ctl === '0, av_wait}, 2'h3);
    i_rst <= 1'b0;
    tick(1);
    av(1'b0, `SIF_OFF_CTRL, 32'h0);
    check("ctrl_rst", rdat, 32'h3);
    av(1'b0, `SIF_OFF_STATUS, 32'h0);
    check("stat_rst", rdat, 32'h0);
    av(1'b1, 4'h1, 32'hFFFFFFFF);
    av(1'b0, 4'h1, 32'h0);
    check("unmapped", rdat, 32'h0);
    av_be <= 4'h0;
    av(1'b1, `SIF_OFF_CTRL, 32'h0);
    av_be <= 4'hF;
    av(1'b0, `SIF_OFF_CTRL, 32'h0);
    check("ctrl_be", rdat, 32'h3);
    check("l4_empty", ctl.level4_accept, 1'b1);
    $display("Registers done");
    l3.alpha_from_reg <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      ar = rng[23:0];
      store(rng[24], i[1:0], rng[25]);
      wait_ctl(1);
      check("acc_reg", {ctl.level4_accept, ctl.level4_active}, 2'h2);
      tick(12);
    end
    av(1'b0, `SIF_OFF_STATUS, 32'h0);
    check("mode_zero", rdat[5:4], 2'h0);
    $display("Stores done");
    base.x_octet_addr <= 21'h0ABCDE;
    base.y_octet_addr <= 21'h0ABCDE;
    base.z_octet_addr <= 21'h0ABCDE;
    base.z_octet_valid <= 1'b1;
    base.x_active <= 1'b1;
    base.y_active <= 1'b1;
    base.x_fill_next <= 1'b1;
    base.y_fill_next <= 1'b1;
    l3.seq <= SIF_SEQ_IDLE;
    tick(1);
    l3.seq <= SIF_SEQ_NONE;
    base.x_fill_next <= 1'b0;
    base.y_fill_next <= 1'b0;
    tick(1);
    check("xy_valid", {ctl.x_octet_valid, ctl.y_octet_valid}, 2'h3);
    check("idle_hold", {ctl.stack_entry_addr, ctl.load_gates}, {ar, 4'h0});
    tick(2);
    check("z_match", {ctl.z_matches_x, ctl.z_matches_y}, 2'h3);
    pre_full <= 1'b1;
    l3.fw_cmd <= 1'b1;
    tick(1);
    l3.fw_cmd <= 1'b0;
    tick(4);
    check("fw_drain", {ctl.forced_write_wait, ctl.fw_to_mbu}, 2'h0);
    pre_full <= 1'b0;
    wait_ctl(0);
    check("fw_wait", ctl.forced_write_wait, 1'b1);
    tick(1);
    check("fw_hold", ctl.forced_write_wait, 1'b1);
    check("z_to_x", {ctl.z_to_x_update, ctl.z_to_y_update}, 2'h3);
    wait_ctl(2);
    av(1'b0, `SIF_OFF_STATUS, 32'h0);
    check("fw_idle", rdat[1:0], 2'h0);
    exp_fw++;
    av(1'b0, `SIF_OFF_FWCNT, 32'h0);
    check("fw_count", rdat, exp_fw);
    av(1'b0, `SIF_OFF_PEND, 32'h0);
    check("pend_reg", rdat, {8'h00, exp_pend[$]});
    l3.x_valid_clr <= 1'b1;
    l3.y_valid_clr <= 1'b1;
    tick(1);
    l3.x_valid_clr <= 1'b0;
    l3.y_valid_clr <= 1'b0;
    tick(3);
    check("xy_clr", {ctl.x_octet_valid, ctl.y_octet_valid, ctl.z_matches_x, ctl.z_matches_y},
      4'h0);
    $display("Forced write done");
    av(1'b1, `SIF_OFF_CTRL, 32'h0);
    l3.fw_cmd <= 1'b1;
    l3.seq <= SIF_SEQ_MEMSTORE;
    l3.adder_result_reg <= ar ^ 24'h000800;
    tick(1);
    l3.seq <= SIF_SEQ_NONE;
    l3.fw_cmd <= 1'b0;
    tick(4);
    check("seq_off", {ctl.pending_store_addr, ctl.forced_write_wait}, {exp_pend[$], 1'b0});
    av(1'b1, `SIF_OFF_CTRL, 32'h3);
    lat <= 4'h4;
    l3.alpha_from_reg <= 1'b0;
    ar = 24'h123458;
    store(1'b0, 2'h0, 1'b0);
    tick(1);
    check("l4_loop", {ctl.level4_accept, ctl.l4_to_l5}, 2'h0);
    l3.adder_result_reg <= 24'h654320;
    wait_ctl(1);
    check("withhold", {ctl.level4_accept, ctl.pending_store_valid}, 2'h1);
    wait_ctl(3);
    check("pend_clr", ctl.pending_store_valid, 1'b0);
    tick(20);
    ar = 24'h654320;
    store(1'b1, 2'h0, 1'b0);
    wait_ctl(1);
    check("same_addr", ctl.level4_accept, 1'b1);
    $display("Level 4 done");
    report_and_stop();
  end
endmodule
